// ### src/smls_pkg.sv
package smls_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] SMLS_OFS_ACCEL_RATIO = 8'h08;
  localparam logic [7:0] SMLS_OFS_MAX_ACCEL = 8'h09;
  localparam logic [7:0] SMLS_OFS_DEAD_ZONE = 8'h0A;
  localparam logic [7:0] SMLS_OFS_SAT_OFFSET = 8'h0B;
  localparam logic [7:0] SMLS_OFS_SAT_SLOPE = 8'h0C;
  localparam logic [7:0] SMLS_OFS_DRV_OFFSET = 8'h0E;
  localparam logic [7:0] SMLS_OFS_DRV_FLOOR = 8'h0F;
  localparam logic [7:0] SMLS_OFS_DRV_CEIL = 8'h10;
  localparam logic [7:0] SMLS_OFS_OVL_THR = 8'h12;
  localparam logic [7:0] SMLS_OFS_POS_LO = 8'h14;
  localparam logic [7:0] SMLS_OFS_POS_HI = 8'h16;
  localparam logic [7:0] SMLS_OFS_OVL_PERIOD = 8'h2A;
  localparam logic [7:0] SMLS_OFS_STATUS = 8'h30;
  localparam logic [7:0] SMLS_OFS_IRQ_MASK = 8'h31;

  // ------------------------------------------------------------
  // reset values and limits
  // ------------------------------------------------------------
  localparam logic [7:0] SMLS_RST_ACCEL_RATIO = 8'h19;
  localparam logic [7:0] SMLS_RST_MAX_ACCEL = 8'h2D;
  localparam logic [9:0] SMLS_RST_DRV_CEIL = 10'h3FF;
  localparam logic [15:0] SMLS_RST_OVL_THR = 16'h03FE;
  localparam logic [14:0] SMLS_RST_POS_LO = 15'h2983;
  localparam logic [14:0] SMLS_RST_POS_HI = 15'h5671;
  localparam logic [7:0] SMLS_RST_OVL_PERIOD = 8'h96;
  localparam logic [7:0] SMLS_MAX_RATIO = 8'h32;
  localparam logic [7:0] SMLS_MAX_SETTING = 8'hFE;
  localparam logic [9:0] SMLS_PWM_MAX = 10'h3FF;
  localparam logic [15:0] SMLS_PCT_DIV = 16'h0064;
  localparam int SMLS_SLOPE_SHIFT = 8;

  // status bit positions
  localparam int SMLS_ST_POS_LIMIT = 0;
  localparam int SMLS_ST_OVERLOAD = 1;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SMLS_CLK_PERIOD_NS = 4;
  localparam int SMLS_OVL_TICK_MS = 4;
  localparam int SMLS_OVL_TICK_CYC = SMLS_OVL_TICK_MS * 1000000 / SMLS_CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SMLS_PROF_RECT = 2'b00,
    SMLS_PROF_TRI = 2'b01,
    SMLS_PROF_PEAK = 2'b10
  } smls_prof_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } smls_bus_req_t;

  typedef struct packed {
    logic valid;
    logic synchronized;
    logic [15:0] op_time;
  } smls_move_cmd_t;

  typedef struct packed {
    logic valid;
    logic synchronized;
    logic [7:0] accel_time;
    logic [7:0] decel_time;
    smls_prof_t shape;
  } smls_move_res_t;

  typedef struct packed {
    logic pos_mode;
    logic cont_rot;
    logic signed [15:0] pos_err;
    logic signed [11:0] pwm_raw;
  } smls_drive_in_t;

  typedef struct packed {
    logic [9:0] pwm_mag;
    logic pwm_rev;
    logic signed [15:0] pos_err;
  } smls_drive_out_t;

  typedef struct packed {
    logic valid;
    logic limited;
    logic [14:0] target;
  } smls_pos_res_t;

  typedef struct packed {
    logic [7:0] ratio;
    logic [7:0] max_accel;
    logic [7:0] dead_zone;
    logic [7:0] sat_off;
    logic [14:0] sat_slope;
    logic [7:0] drv_off;
    logic [7:0] drv_floor;
    logic [9:0] drv_ceil;
    logic [15:0] ovl_thr;
    logic [14:0] pos_lo;
    logic [14:0] pos_hi;
    logic [7:0] ovl_period;
    logic [1:0] status;
    logic [1:0] mask;
    logic [15:0] rdata;
    logic irq;
    smls_move_res_t move;
    smls_drive_out_t drive;
    smls_pos_res_t pos;
    logic overload;
    logic [23:0] tick_cnt;
    logic [7:0] ovl_cnt;
  } smls_state_t;
endpackage : smls_pkg

// ### src/smls_top.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
// What this block does
// - accel time = operating time times ratio percent
// - decel time equals accel time
// - ratio zero gives rectangular profile
// - ratio below 50 reports triangular profile
// - accel time capped by max accel setting
// - max accel zero forces rectangular profile
// - dead zone only in position mode
// - saturator offset shapes curve, not continuous
// - slope over 256, zero disables, continuous bypasses
// - signed drive offset added except continuous rotation
// - zero stops motor, never above 1023
// - floor setting is lower drive limit
// - ceiling setting clamps drive, 10 bits
// - overload when force over threshold too long
// - threshold above 1023 never overloads
// - below lower limit: flag, clamp to minimum
// - above upper limit: flag, clamp to maximum
// - period counts 4 ms ticks, zero disables
module smls_top #(
  parameter int TICK_CYCLES = smls_pkg::SMLS_OVL_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire smls_pkg::smls_bus_req_t bus_i,
  output logic [15:0] rdata_o,
  output logic irq_o,
  input wire smls_pkg::smls_move_cmd_t move_i,
  output smls_pkg::smls_move_res_t move_o,
  input wire smls_pkg::smls_drive_in_t drive_i,
  output smls_pkg::smls_drive_out_t drive_o,
  input wire logic [9:0] force_i,
  output logic overload_o,
  input wire logic pos_req_valid_i,
  input wire logic [14:0] pos_req_i,
  output smls_pkg::smls_pos_res_t pos_o
);
  import smls_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [9:0] sat10(input logic [23:0] x);
    sat10 = (x > 24'(SMLS_PWM_MAX)) ? SMLS_PWM_MAX : x[9:0];
  endfunction : sat10

  function automatic logic [7:0] sat8(input logic [15:0] x, input logic [7:0] lim);
    sat8 = (x > 16'(lim)) ? lim : x[7:0];
  endfunction : sat8

  function automatic logic [15:0] abs16(input logic signed [15:0] x);
    logic [16:0] t;
    t = x[15] ? (17'h00000 - 17'(x)) : 17'(x);
    // most negative error gives 32768 exactly, t[16] is never set and nothing saturates
    abs16 = t[16] ? 16'hFFFF : t[15:0];
  endfunction : abs16

  smls_state_t r;
  smls_state_t n;

  logic wr_hit;
  logic rd_hit;
  logic [15:0] rd_val;
  logic [23:0] prod;
  logic [23:0] ramp;
  logic [15:0] err_abs;
  logic signed [15:0] err_use;
  logic [10:0] mag;
  logic [10:0] mag_sat;
  logic [30:0] slope_prod;
  logic [23:0] sat_lim;
  logic signed [12:0] pwm_s;
  logic [12:0] pwm_abs;
  logic [9:0] out_mag;
  logic out_rev;
  logic [9:0] ceil_eff;
  logic force_over;
  logic ovl_armed;
  logic tick;
  logic ovl_now;
  logic [1:0] events;

  always_comb begin
    n = r;
    wr_hit = bus_i.wr;
    rd_hit = bus_i.rd;

    // ------------------------------------------------------------
    // register writes, settings saturated to their valid range
    // ------------------------------------------------------------
    if (wr_hit) begin
      unique case (bus_i.addr)
        SMLS_OFS_ACCEL_RATIO: n.ratio = sat8(16'(bus_i.wdata[7:0]), SMLS_MAX_RATIO);
        SMLS_OFS_MAX_ACCEL: n.max_accel = sat8(16'(bus_i.wdata[7:0]), SMLS_MAX_SETTING);
        SMLS_OFS_DEAD_ZONE: n.dead_zone = bus_i.wdata[7:0];
        SMLS_OFS_SAT_OFFSET: n.sat_off = bus_i.wdata[7:0];
        SMLS_OFS_SAT_SLOPE: n.sat_slope = bus_i.wdata[14:0];
        SMLS_OFS_DRV_OFFSET: n.drv_off = bus_i.wdata[7:0];
        SMLS_OFS_DRV_FLOOR: n.drv_floor = sat8(16'(bus_i.wdata[7:0]), SMLS_MAX_SETTING);
        SMLS_OFS_DRV_CEIL: n.drv_ceil = sat10(24'(bus_i.wdata));
        SMLS_OFS_OVL_THR: n.ovl_thr = bus_i.wdata;
        SMLS_OFS_POS_LO: n.pos_lo = bus_i.wdata[14:0];
        SMLS_OFS_POS_HI: n.pos_hi = bus_i.wdata[14:0];
        SMLS_OFS_OVL_PERIOD: n.ovl_period = sat8(16'(bus_i.wdata[7:0]), SMLS_MAX_SETTING);
        SMLS_OFS_IRQ_MASK: n.mask = bus_i.wdata[1:0];
        default: ;
      endcase
    end

    // ------------------------------------------------------------
    // register reads, data valid in the next cycle only
    // ------------------------------------------------------------
    rd_val = 16'h0000;
    unique case (bus_i.addr)
      SMLS_OFS_ACCEL_RATIO: rd_val = 16'(r.ratio);
      SMLS_OFS_MAX_ACCEL: rd_val = 16'(r.max_accel);
      SMLS_OFS_DEAD_ZONE: rd_val = 16'(r.dead_zone);
      SMLS_OFS_SAT_OFFSET: rd_val = 16'(r.sat_off);
      SMLS_OFS_SAT_SLOPE: rd_val = 16'(r.sat_slope);
      SMLS_OFS_DRV_OFFSET: rd_val = 16'(r.drv_off);
      SMLS_OFS_DRV_FLOOR: rd_val = 16'(r.drv_floor);
      SMLS_OFS_DRV_CEIL: rd_val = 16'(r.drv_ceil);
      SMLS_OFS_OVL_THR: rd_val = r.ovl_thr;
      SMLS_OFS_POS_LO: rd_val = 16'(r.pos_lo);
      SMLS_OFS_POS_HI: rd_val = 16'(r.pos_hi);
      SMLS_OFS_OVL_PERIOD: rd_val = 16'(r.ovl_period);
      SMLS_OFS_STATUS: rd_val = {13'h0000, r.overload, r.status};
      SMLS_OFS_IRQ_MASK: rd_val = 16'(r.mask);
      default: rd_val = 16'h0000;
    endcase
    n.rdata = rd_hit ? rd_val : 16'h0000;

    // ------------------------------------------------------------
    // motion profile for timed move commands
    // ------------------------------------------------------------
    prod = 24'(move_i.op_time) * 24'(r.ratio);
    ramp = prod / 24'(SMLS_PCT_DIV);
    n.move.valid = move_i.valid;
    if (move_i.valid) begin
      n.move.synchronized = move_i.synchronized;
      if (r.ratio == 8'h00 || r.max_accel == 8'h00) begin
        n.move.accel_time = 8'h00;
        n.move.shape = SMLS_PROF_RECT;
      end else begin
        // cap on the ramp only; the cruise share grows to keep op time
        n.move.accel_time = sat8(ramp[15:0], r.max_accel);
        if (ramp > 24'h00FFFF) begin
          n.move.accel_time = r.max_accel;
        end
        n.move.shape = (r.ratio < SMLS_MAX_RATIO) ? SMLS_PROF_TRI : SMLS_PROF_PEAK;
      end
      n.move.decel_time = n.move.accel_time;
    end

    // ------------------------------------------------------------
    // drive path: dead zone, saturator, offset, clamp
    // ------------------------------------------------------------
    err_abs = abs16(drive_i.pos_err);
    err_use = drive_i.pos_err;
    if (drive_i.pos_mode && err_abs <= 16'(r.dead_zone)) begin
      err_use = 16'sh0000;
    end
    n.drive.pos_err = err_use;

    // most negative raw drive saturates instead of wrapping to zero
    if (drive_i.pwm_raw == 12'sh800) begin
      mag = 11'h7FF;
    end else begin
      mag = drive_i.pwm_raw[11] ? (11'h000 - drive_i.pwm_raw[10:0]) : drive_i.pwm_raw[10:0];
    end
    slope_prod = 31'(abs16(err_use)) * 31'(r.sat_slope);
    sat_lim = 24'(r.sat_off) + 24'(slope_prod >> SMLS_SLOPE_SHIFT);
    mag_sat = mag;
    if (!drive_i.cont_rot && r.sat_slope != 15'h0000) begin
      if (24'(mag) > sat_lim) begin
        mag_sat = 11'(sat_lim);
      end
    end

    pwm_s = drive_i.pwm_raw[11] ? -13'sd0 - $signed(13'(mag_sat)) : $signed(13'(mag_sat));
    if (!drive_i.cont_rot) begin
      pwm_s = pwm_s + 13'(signed'(r.drv_off));
    end
    out_rev = pwm_s[12];
    pwm_abs = out_rev ? (13'h0000 - 13'(pwm_s)) : 13'(pwm_s);

    // ceiling never exceeds full scale, floor never beats the ceiling
    ceil_eff = sat10(24'(r.drv_ceil));
    out_mag = sat10(24'(pwm_abs));
    if (out_mag > ceil_eff) begin
      out_mag = ceil_eff;
    end
    if (out_mag < 10'(r.drv_floor)) begin
      out_mag = 10'(r.drv_floor);
    end
    if (out_mag > ceil_eff) begin
      out_mag = ceil_eff;
    end
    if (drive_i.pwm_raw == 12'sh000) begin
      out_mag = 10'h000;
      out_rev = 1'b0;
    end
    n.drive.pwm_mag = out_mag;
    n.drive.pwm_rev = out_rev;

    // ------------------------------------------------------------
    // overload detection on 4 ms ticks
    // ------------------------------------------------------------
    tick = (r.tick_cnt == 24'(TICK_CYCLES - 1));
    n.tick_cnt = tick ? 24'h000000 : r.tick_cnt + 24'h000001;
    ovl_armed = (r.ovl_thr <= 16'(SMLS_PWM_MAX)) && (r.ovl_period != 8'h00);
    force_over = 16'(force_i) > r.ovl_thr;
    if (!ovl_armed || !force_over) begin
      n.ovl_cnt = 8'h00;
    end else if (tick && r.ovl_cnt != 8'hFF) begin
      n.ovl_cnt = r.ovl_cnt + 8'h01;
    end
    // free tick, so the hold is judged to within one tick
    ovl_now = ovl_armed && force_over && (r.ovl_cnt > r.ovl_period);
    n.overload = ovl_now;

    // ------------------------------------------------------------
    // position request clamping
    // ------------------------------------------------------------
    n.pos.valid = pos_req_valid_i;
    if (pos_req_valid_i) begin
      n.pos.limited = 1'b0;
      n.pos.target = pos_req_i;
      if (pos_req_i < r.pos_lo) begin
        n.pos.target = r.pos_lo;
        n.pos.limited = 1'b1;
      end else if (pos_req_i > r.pos_hi) begin
        n.pos.target = r.pos_hi;
        n.pos.limited = 1'b1;
      end
    end

    // ------------------------------------------------------------
    // sticky status, clear on read, set wins over clear
    // ------------------------------------------------------------
    events = 2'b00;
    events[SMLS_ST_POS_LIMIT] = n.pos.valid && n.pos.limited;
    events[SMLS_ST_OVERLOAD] = ovl_now && !r.overload;
    n.status = ((rd_hit && bus_i.addr == SMLS_OFS_STATUS) ? 2'b00 : r.status) | events;
    n.irq = |(n.status & n.mask);

    if (sys_rst_i) begin
      n = '0;
      n.ratio = SMLS_RST_ACCEL_RATIO;
      n.max_accel = SMLS_RST_MAX_ACCEL;
      n.drv_ceil = SMLS_RST_DRV_CEIL;
      n.ovl_thr = SMLS_RST_OVL_THR;
      n.pos_lo = SMLS_RST_POS_LO;
      n.pos_hi = SMLS_RST_POS_HI;
      n.ovl_period = SMLS_RST_OVL_PERIOD;
    end
  end

  always_ff @(posedge clk_i) begin
    r <= n;
  end

  // ------------------------------------------------------------
  // outputs straight from state
  // ------------------------------------------------------------
  assign rdata_o = r.rdata;
  assign irq_o = r.irq;
  assign move_o = r.move;
  assign drive_o = r.drive;
  assign overload_o = r.overload;
  assign pos_o = r.pos;
endmodule : smls_top

// ### verif/smls_assertions.sv
`timescale 1ns/10ps
module smls_assertions
  import smls_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire smls_pkg::smls_bus_req_t bus_i,
  input wire logic [15:0] rdata_o,
  input wire smls_pkg::smls_move_cmd_t move_i,
  input wire smls_pkg::smls_move_res_t move_o,
  input wire smls_pkg::smls_drive_in_t drive_i,
  input wire smls_pkg::smls_drive_out_t drive_o,
  input wire logic [9:0] force_i,
  input wire logic overload_o,
  input wire logic pos_req_valid_i,
  input wire logic [14:0] pos_req_i,
  input wire smls_pkg::smls_pos_res_t pos_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence s_force_quiet;
    (force_i == 10'h000) [*3];
  endsequence
  sequence s_move_req;
    move_i.valid;
  endsequence
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 16'h0000)
    else $error("read data outside read answer cycle");
  a_move_latency: assert property (s_move_req |=> move_o.valid)
    else $error("move result missing");
  a_decel_equal: assert property (move_o.valid |-> move_o.decel_time == move_o.accel_time)
    else $error("decel differs from accel");
  a_rect_no_ramp: assert property (move_o.valid && move_o.shape == SMLS_PROF_RECT
      |-> move_o.accel_time == 8'h00)
    else $error("rectangular profile with ramp");
  a_move_hold: assert property (!move_o.valid |-> $stable(move_o.accel_time))
    else $error("move result changed without command");
  a_pos_result: assert property (pos_req_valid_i |=> pos_o.valid
      && (pos_o.limited || pos_o.target == $past(pos_req_i)))
    else $error("position target wrong");
  a_ovl_release: assert property (s_force_quiet |=> !overload_o)
    else $error("overload without force");
  a_pwm_stop: assert property (drive_i.pwm_raw == 12'h000
      |=> drive_o.pwm_mag == 10'h000 && !drive_o.pwm_rev)
    else $error("zero drive not stopped");
  a_cont_sign: assert property (drive_i.cont_rot && drive_i.pwm_raw < 0
      |=> drive_o.pwm_rev)
    else $error("drive direction lost");
endmodule : smls_assertions

bind smls_top smls_assertions smls_assertions_inst (.clk_i, .sys_rst_i, .bus_i, .rdata_o,
  .move_i, .move_o, .drive_i, .drive_o, .force_i, .overload_o, .pos_req_valid_i,
  .pos_req_i, .pos_o);

// ### verif/smls_host.sv
`timescale 1ns/10ps
module smls_host
  import smls_pkg::*;
(
  input wire logic clk_i,
  output smls_pkg::smls_bus_req_t bus_o
);
  // strobes drop at the taking edge, so back to back calls leave one idle cycle
  initial bus_o = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus_o <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_o <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    bus_o <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_o <= '0;
  endtask : rd
endmodule : smls_host

// ### verif/smls_tb.sv
`timescale 1ns/10ps
module testbench;
  import smls_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  smls_bus_req_t bus;
  logic [15:0] rdata;
  logic irq;
  smls_move_cmd_t mc = '0;
  smls_move_res_t mr;
  smls_drive_in_t drv = '0;
  smls_drive_out_t dr;
  logic [9:0] frc = '0;
  logic ovl;
  logic pv = 1'b0;
  logic [14:0] pq = '0;
  smls_pos_res_t pr;
  logic rd_q = 1'b0;
  logic [14:0] rnd;
  int fails = 0;
  int compares = 0;
  logic [31:0] qr[$];
  logic [31:0] qm[$];
  logic [31:0] qp[$];
  logic [7:0] ra[16] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h12,
    8'h14, 8'h16, 8'h2A, 8'h30, 8'h31, 8'h0D, 8'h05};
  logic [15:0] rv[16] = '{16'h19, 16'h2D, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h3FF,
    16'h3FE, 16'h2983, 16'h5671, 16'h96, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [7:0] mrat[4] = '{8'h14, 8'h3C, 8'h00, 8'h14};
  logic [7:0] mmax[4] = '{8'h2D, 8'h2D, 8'h2D, 8'h00};
  logic [17:0] mexp[4] = '{{8'h14, 8'h14, 2'h1}, {8'h2D, 8'h2D, 2'h2}, 18'h0, 18'h0};

  smls_top #(.TICK_CYCLES(4)) smls_top_inst (.clk_i, .sys_rst_i, .bus_i(bus), .rdata_o(rdata),
    .irq_o(irq), .move_i(mc), .move_o(mr), .drive_i(drv), .drive_o(dr), .force_i(frc),
    .overload_o(ovl), .pos_req_valid_i(pv), .pos_req_i(pq), .pos_o(pr));
  smls_host smls_host_inst (.clk_i, .bus_o(bus));

  initial forever #2 clk_i = ~clk_i;
  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic pop(ref logic [31:0] q[$], input logic [31:0] seen, input string nm);
    if (q.size() == 0) chk(nm, seen, 32'hFFFFFFFF);
    else chk(nm, seen, q.pop_front());
  endtask : pop
  always @(posedge clk_i) rd_q <= bus.rd;
  always @(negedge clk_i) begin
    if (rd_q) pop(qr, 32'(rdata), "rdata");
    if (mr.valid) pop(qm, 32'({mr.synchronized, mr.accel_time, mr.decel_time, mr.shape}),
      "move");
    if (pr.valid) pop(qp, 32'({pr.limited, pr.target}), "position");
  end
  task automatic summarize;
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    qr.push_back(32'(e));
    smls_host_inst.rd(a);
  endtask : rd
  task automatic mv(input logic s, input logic [17:0] e);
    qm.push_back(32'({s, e}));
    @(posedge clk_i);
    mc <= '{1'b1, s, 16'd100};
    @(posedge clk_i);
    mc.valid <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : mv
  task automatic ps(input logic [14:0] p, input logic [15:0] e);
    qp.push_back(32'(e));
    @(posedge clk_i);
    pv <= 1'b1;
    pq <= p;
    @(posedge clk_i);
    pv <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : ps
  task automatic dv(input smls_drive_in_t d, input logic [10:0] e, input logic [15:0] er);
    @(posedge clk_i);
    drv <= d;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("drive", 32'({dr.pwm_mag, dr.pwm_rev, dr.pos_err}), 32'({e, er}));
  endtask : dv
  task automatic ov(input logic [9:0] f, input int n, input logic e);
    @(posedge clk_i);
    frc <= f;
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    chk("overload", 32'(ovl), 32'(e));
  endtask : ov

  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    summarize();
  end
  initial begin
    void'($urandom(73));
    rnd = 15'h2983 + 15'($urandom % 32'h2CEE);
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    foreach (mrat[i]) begin
      smls_host_inst.wr(8'h08, 16'(mrat[i]));
      smls_host_inst.wr(8'h09, 16'(mmax[i]));
      mv(1'(i), mexp[i]);
    end
    rd(8'h08, 16'h0014);
    smls_host_inst.wr(8'h31, 16'h0001);
    ps(15'h0100, 16'hA983);
    ps(15'h7000, 16'hD671);
    ps(rnd, 16'(rnd));
    @(negedge clk_i);
    chk("irq", 32'(irq), 32'h1);
    rd(8'h30, 16'h0001);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("irq", 32'(irq), 32'h0);
    rd(8'h30, 16'h0000);
    smls_host_inst.wr(8'h0E, 16'h000A);
    smls_host_inst.wr(8'h0F, 16'h0032);
    smls_host_inst.wr(8'h10, 16'h012C);
    smls_host_inst.wr(8'h0A, 16'h0005);
    smls_host_inst.wr(8'h0B, 16'h000A);
    smls_host_inst.wr(8'h0C, 16'h0100);
    dv('{1'b1, 1'b0, 16'sd3, 12'sd100}, {10'd50, 1'b0}, 16'd0);
    dv('{1'b0, 1'b0, 16'sd100, 12'sd200}, {10'd120, 1'b0}, 16'd100);
    dv('{1'b0, 1'b1, 16'sd3, 12'sd500}, {10'd300, 1'b0}, 16'd3);
    dv('{1'b0, 1'b1, 16'sd3, -12'sd80}, {10'd80, 1'b1}, 16'd3);
    dv('{1'b0, 1'b0, 16'sd3, 12'sd0}, {10'd0, 1'b0}, 16'd3);
    smls_host_inst.wr(8'h0E, 16'h00F6);
    dv('{1'b0, 1'b0, 16'sd100, 12'sd200}, {10'd100, 1'b0}, 16'd100);
    smls_host_inst.wr(8'h0C, 16'h0000);
    dv('{1'b0, 1'b0, 16'sd100, 12'sd200}, {10'd190, 1'b0}, 16'd100);
    smls_host_inst.wr(8'h12, 16'h0064);
    smls_host_inst.wr(8'h2A, 16'h0002);
    ov(10'd200, 4, 1'b0);
    ov(10'd200, 40, 1'b1);
    chk("irq", 32'(irq), 32'h0);
    ov(10'd0, 6, 1'b0);
    rd(8'h30, 16'h0002);
    smls_host_inst.wr(8'h2A, 16'h0000);
    ov(10'd200, 40, 1'b0);
    ov(10'd0, 6, 1'b0);
    smls_host_inst.wr(8'h2A, 16'h0002);
    smls_host_inst.wr(8'h12, 16'h8010);
    ov(10'h3FF, 40, 1'b0);
    repeat (4) @(posedge clk_i);
    summarize();
  end
endmodule : testbench
